// >>> hdl/cache_tag_coherency_ctl.sv
// Tag array, processor lookup, snoop pipeline and APB control registers
// Assumes system bus and processor signals are synchronous to pclk
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module cache_tag_coherency_ctl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_on_reset_input,
   input wire logic proc_req,
   input wire logic [17:0] internal_module_address,
   input wire logic [23:0] proc_ptag,
   input wire logic proc_write,
   input wire logic proc_asi_store,
   input wire logic [7:0] proc_asi,
   input wire logic proc_super,
   input wire logic tlb_hit,
   input wire logic perm_ok,
   output logic proc_ready,
   output logic proc_done,
   output logic proc_hit,
   output logic proc_ok,
   output logic cache_wr,
   output logic bus_req,
   output cache_tag_pkg::bus_cmd_t bus_cmd,
   input wire logic bus_rdy,
   input wire logic bus_shared_n,
   input wire logic snoop_valid,
   input wire cache_tag_pkg::bus_cmd_t snoop_cmd,
   input wire logic [63:0] snoop_mad,
   output logic snoop_shared_n
);
   import cache_tag_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] line_tag_array [ENTRIES];
   logic arr_we;
   logic [INDEX_W-1:0] arr_idx;
   logic [31:0] arr_data;
   logic [1:0] ctrl_reg, ctrl_next;
   logic [31:0] prdata_reg, prdata_next;
   logic copy_back, size256;
   logic por_s1_reg, por_s2_reg;
   logic sweep_reg, sweep_next;
   logic [INDEX_W-1:0] sweep_idx_reg, sweep_idx_next;
   logic s1_valid_reg, s1_valid_next;
   bus_cmd_t s1_cmd_reg, s1_cmd_next;
   logic [INDEX_W-1:0] s1_idx_reg, s1_idx_next;
   logic s1_sub_reg, s1_sub_next;
   logic [TAG_W-1:0] s1_tag_reg, s1_tag_next;
   logic [31:0] s1_entry;
   logic s1_hit, s1_clean;
   logic s2_we_reg, s2_we_next;
   logic s2_share_reg, s2_share_next;
   logic [INDEX_W-1:0] s2_idx_reg, s2_idx_next;
   logic [31:0] s2_data_reg, s2_data_next;
   logic shared_n_reg, shared_n_next;
   proc_state_t st_reg, st_next;
   logic [17:0] req_addr_reg, req_addr_next;
   logic [TAG_W-1:0] req_tag_reg, req_tag_next;
   logic req_wr_reg, req_wr_next;
   logic req_flush_reg, req_flush_next;
   logic req_su_reg, req_su_next;
   logic req_tlb_reg, req_tlb_next;
   logic req_perm_reg, req_perm_next;
   logic shr_reg, shr_next;
   logic done_reg, done_next;
   logic hit_reg, hit_next;
   logic ok_reg, ok_next;
   logic cwr_reg, cwr_next;
   bus_cmd_t cmd_reg, cmd_next;
   logic [INDEX_W-1:0] p_idx;
   logic p_sub;
   logic [31:0] p_entry, p_wdata, p_fill;
   logic p_we, p_tag_eq, p_hit, p_sh, p_m, stall;

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, read data captured in the setup cycle
   assign copy_back = ctrl_reg[CTRL_COPY_BACK];
   assign size256 = ctrl_reg[CTRL_SIZE256];
   assign pready = 1'b1;
   assign pslverr = psel && penable && (paddr != CTRL_OFF) && (paddr != STATUS_OFF);
   assign prdata = prdata_reg;

   always_comb begin
      ctrl_next = ctrl_reg;
      prdata_next = prdata_reg;
      if (psel && penable && pwrite && paddr == CTRL_OFF) begin
         ctrl_next = pwdata[1:0];
      end
      if (psel && !penable) begin
         prdata_next = 32'h0000_0000;
         if (paddr == CTRL_OFF) begin
            prdata_next[1:0] = ctrl_reg;
         end else if (paddr == STATUS_OFF) begin
            prdata_next[0] = sweep_reg;
            prdata_next[1] = hit_reg;
            prdata_next[2] = ok_reg;
            prdata_next[9:4] = st_reg;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET;
         prdata_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         prdata_reg <= prdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-on invalidation sweep; 4096 cycles, lookups wait for it, snoops during it are dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         por_s1_reg <= 1'b0;
         por_s2_reg <= 1'b0;
      end else begin
         por_s1_reg <= power_on_reset_input;
         por_s2_reg <= por_s1_reg;
      end
   end

   always_comb begin
      sweep_next = sweep_reg;
      sweep_idx_next = sweep_idx_reg;
      if (sweep_reg) begin
         sweep_idx_next = sweep_idx_reg + 12'h001;
      end
      if (por_s2_reg) begin
         sweep_next = 1'b1;
      end else if (sweep_reg && sweep_idx_reg == SWEEP_LAST) begin
         sweep_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sweep_reg <= 1'b1;
         sweep_idx_reg <= 12'h000;
      end else begin
         sweep_reg <= sweep_next;
         sweep_idx_reg <= sweep_idx_next;
      end
   end

   a_sweep_clear: assert property (@(posedge pclk) disable iff (!presetn)
      sweep_reg |=> line_tag_array[$past(sweep_idx_reg)][V_BASE:V_BASE-1] == 2'h0)
      else $error("sweep left a valid bit set");

   ////////////////////////////////////////////////////////////////////////////
   // Tag array write port: sweep, then snoop, then processor
   assign stall = sweep_reg || s2_we_reg;

   always_comb begin
      arr_we = 1'b0;
      arr_idx = p_idx;
      arr_data = p_wdata;
      if (sweep_reg) begin
         arr_we = 1'b1;
         arr_idx = sweep_idx_reg;
         arr_data = 32'h0000_0000;
      end else if (s2_we_reg) begin
         arr_we = 1'b1;
         arr_idx = s2_idx_reg;
         arr_data = s2_data_reg;
      end else if (p_we) begin
         arr_we = 1'b1;
      end
   end

   always_ff @(posedge pclk) begin
      if (arr_we) begin
         line_tag_array[arr_idx] <= arr_data;
      end
   end

   a_wt_valid_only: assert property (@(posedge pclk) disable iff (!presetn)
      (p_we && !stall && !copy_back) |-> (p_wdata[SH_BASE:M_BASE-1] == 4'h0))
      else $error("write-through entry got shared or owned bits");

   ////////////////////////////////////////////////////////////////////////////
   // Snoop pipeline: A latches, A+1 looks up, A+2 writes, A+3 drives shared
   always_comb begin
      s1_valid_next = snoop_valid && !sweep_reg && snoop_cmd != CMD_NONE && snoop_cmd != CMD_BLOCK_RD;
      s1_cmd_next = snoop_cmd;
      s1_idx_next = size256 ? {snoop_mad[51:46], snoop_mad[11:6]} : {snoop_mad[50:46], snoop_mad[11:5]};
      s1_sub_next = snoop_mad[5];
      s1_tag_next = snoop_mad[35:12];
      s1_entry = line_tag_array[s1_idx_reg];
      s1_hit = s1_valid_reg && s1_entry[TAG_MSB:TAG_LSB] == s1_tag_reg && s1_entry[V_BASE-int'(s1_sub_reg)];
      // Owned lines need write-back paths that are not in this block
      s1_clean = !s1_entry[M_BASE-int'(s1_sub_reg)];
      s2_we_next = 1'b0;
      s2_share_next = 1'b0;
      s2_idx_next = s1_idx_reg;
      s2_data_next = s1_entry;
      if (s1_hit && s1_clean) begin
         case (s1_cmd_reg)
            CMD_COH_RD: begin
               if (copy_back) begin
                  s2_share_next = 1'b1;
                  s2_we_next = 1'b1;
                  s2_data_next[SH_BASE-int'(s1_sub_reg)] = 1'b1;
               end
            end
            CMD_COH_RD_INV, CMD_COH_INV, CMD_COH_WR_INV: begin
               s2_we_next = 1'b1;
               s2_data_next[V_BASE-int'(s1_sub_reg)] = 1'b0;
               s2_data_next[SH_BASE-int'(s1_sub_reg)] = 1'b0;
               s2_data_next[M_BASE-int'(s1_sub_reg)] = 1'b0;
            end
            default: begin
            end
         endcase
      end
      shared_n_next = !s2_share_reg;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_valid_reg <= 1'b0;
         s1_cmd_reg <= CMD_NONE;
         s1_idx_reg <= 12'h000;
         s1_sub_reg <= 1'b0;
         s1_tag_reg <= 24'h000000;
         s2_we_reg <= 1'b0;
         s2_share_reg <= 1'b0;
         s2_idx_reg <= 12'h000;
         s2_data_reg <= 32'h0000_0000;
         shared_n_reg <= 1'b1;
      end else begin
         s1_valid_reg <= s1_valid_next;
         s1_cmd_reg <= s1_cmd_next;
         s1_idx_reg <= s1_idx_next;
         s1_sub_reg <= s1_sub_next;
         s1_tag_reg <= s1_tag_next;
         s2_we_reg <= s2_we_next;
         s2_share_reg <= s2_share_next;
         s2_idx_reg <= s2_idx_next;
         s2_data_reg <= s2_data_next;
         shared_n_reg <= shared_n_next;
      end
   end
   assign snoop_shared_n = shared_n_reg;

   a_shared_a3: assert property (@(posedge pclk) disable iff (!presetn)
      (s1_hit && s1_clean && s1_cmd_reg == CMD_COH_RD && copy_back) |-> ##2 !snoop_shared_n)
      else $error("shared not driven in cycle A+3");
   a_snoop_inval: assert property (@(posedge pclk) disable iff (!presetn)
      (s2_we_reg && !sweep_reg && !s2_share_reg) |=> !line_tag_array[$past(s2_idx_reg)][V_BASE-int'($past(s1_sub_reg,2))])
      else $error("snooped invalidate left line valid");

   ////////////////////////////////////////////////////////////////////////////
   // Processor lookup and line state machine
   always_comb begin
      p_idx = size256 ? req_addr_reg[17:6] : req_addr_reg[16:5];
      p_sub = req_addr_reg[5];
      p_entry = line_tag_array[p_idx];
      p_tag_eq = p_entry[TAG_MSB:TAG_LSB] == req_tag_reg;
      p_hit = p_tag_eq && p_entry[V_BASE-int'(p_sub)];
      p_sh = p_entry[SH_BASE-int'(p_sub)];
      p_m = p_entry[M_BASE-int'(p_sub)];
      // A new tag drops the other sub-block; same tag keeps it
      p_fill = p_tag_eq ? p_entry : 32'h0000_0000;
      p_fill[TAG_MSB:TAG_LSB] = req_tag_reg;
      p_fill[SU_BIT] = req_su_reg;
      p_fill[V_BASE-int'(p_sub)] = 1'b1;
      // Shared only when another holder pulled the shared line low at the last entry
      p_fill[SH_BASE-int'(p_sub)] = copy_back && !req_wr_reg && shr_reg;
      p_fill[M_BASE-int'(p_sub)] = copy_back && req_wr_reg;
   end

   always_comb begin
      st_next = st_reg;
      req_addr_next = req_addr_reg;
      req_tag_next = req_tag_reg;
      req_wr_next = req_wr_reg;
      req_flush_next = req_flush_reg;
      req_su_next = req_su_reg;
      req_tlb_next = req_tlb_reg;
      req_perm_next = req_perm_reg;
      shr_next = shr_reg;
      done_next = 1'b0;
      hit_next = hit_reg;
      ok_next = 1'b0;
      cwr_next = 1'b0;
      cmd_next = cmd_reg;
      p_we = 1'b0;
      p_wdata = p_fill;
      case (st_reg)
         ST_IDLE: begin
            if (proc_req && !sweep_reg) begin
               st_next = ST_LOOK;
               req_addr_next = internal_module_address;
               req_tag_next = proc_ptag;
               req_wr_next = proc_write;
               req_flush_next = proc_asi_store && proc_asi >= ASI_FLUSH_LO && proc_asi <= ASI_FLUSH_HI;
               req_su_next = proc_super;
               req_tlb_next = tlb_hit;
               req_perm_next = perm_ok;
            end
         end
         ST_LOOK: begin
            if (!stall) begin
               hit_next = p_hit;
               st_next = ST_IDLE;
               done_next = 1'b1;
               if (!(req_tlb_reg && req_perm_reg)) begin
                  ok_next = 1'b0;
               end else if (req_flush_reg) begin
                  ok_next = 1'b1;
                  if (p_hit && !p_m) begin
                     p_we = 1'b1;
                     p_wdata = p_entry;
                     p_wdata[V_BASE-int'(p_sub)] = 1'b0;
                     p_wdata[SH_BASE-int'(p_sub)] = 1'b0;
                  end
               end else if (!req_wr_reg && p_hit) begin
                  ok_next = 1'b1;
               end else if (!req_wr_reg) begin
                  done_next = 1'b0;
                  st_next = ST_FILL;
                  cmd_next = copy_back ? CMD_COH_RD : CMD_BLOCK_RD;
               end else if (!copy_back) begin
                  done_next = 1'b0;
                  st_next = ST_BUSW;
                  cmd_next = CMD_COH_WR_INV;
                  cwr_next = p_hit;
               end else if (p_hit && !p_sh) begin
                  ok_next = 1'b1;
                  cwr_next = 1'b1;
                  p_we = 1'b1;
                  p_wdata = p_entry;
                  p_wdata[M_BASE-int'(p_sub)] = 1'b1;
               end else if (p_hit) begin
                  done_next = 1'b0;
                  st_next = ST_INVAL;
                  cmd_next = CMD_COH_INV;
               end else begin
                  done_next = 1'b0;
                  st_next = ST_FILL;
                  cmd_next = CMD_COH_RD_INV;
               end
            end
         end
         ST_FILL: begin
            if (bus_rdy) begin
               shr_next = !bus_shared_n;
               cwr_next = req_wr_reg;
               st_next = ST_UPD;
               cmd_next = CMD_NONE;
            end
         end
         ST_INVAL: begin
            if (bus_rdy) begin
               cwr_next = 1'b1;
               st_next = ST_UPD;
               cmd_next = CMD_NONE;
            end
         end
         ST_UPD: begin
            if (!stall) begin
               p_we = 1'b1;
               hit_next = 1'b1;
               ok_next = 1'b1;
               done_next = 1'b1;
               st_next = ST_IDLE;
            end
         end
         ST_BUSW: begin
            if (bus_rdy) begin
               ok_next = 1'b1;
               done_next = 1'b1;
               cmd_next = CMD_NONE;
               st_next = ST_IDLE;
            end
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= ST_IDLE;
         req_addr_reg <= 18'h00000;
         req_tag_reg <= 24'h000000;
         req_wr_reg <= 1'b0;
         req_flush_reg <= 1'b0;
         req_su_reg <= 1'b0;
         req_tlb_reg <= 1'b0;
         req_perm_reg <= 1'b0;
         shr_reg <= 1'b0;
         done_reg <= 1'b0;
         hit_reg <= 1'b0;
         ok_reg <= 1'b0;
         cwr_reg <= 1'b0;
         cmd_reg <= CMD_NONE;
      end else begin
         st_reg <= st_next;
         req_addr_reg <= req_addr_next;
         req_tag_reg <= req_tag_next;
         req_wr_reg <= req_wr_next;
         req_flush_reg <= req_flush_next;
         req_su_reg <= req_su_next;
         req_tlb_reg <= req_tlb_next;
         req_perm_reg <= req_perm_next;
         shr_reg <= shr_next;
         done_reg <= done_next;
         hit_reg <= hit_next;
         ok_reg <= ok_next;
         cwr_reg <= cwr_next;
         cmd_reg <= cmd_next;
      end
   end

   assign proc_ready = (st_reg == ST_IDLE) && !sweep_reg;
   assign proc_done = done_reg;
   assign proc_hit = hit_reg;
   assign proc_ok = ok_reg;
   assign cache_wr = cwr_reg;
   assign bus_cmd = cmd_reg;
   assign bus_req = (st_reg == ST_FILL) || (st_reg == ST_INVAL) || (st_reg == ST_BUSW);

   a_ok_needs_tlb: assert property (@(posedge pclk) disable iff (!presetn)
      proc_ok |-> (proc_done && req_tlb_reg && req_perm_reg))
      else $error("access completed without translation permission");
   a_fill_then_write: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg == ST_FILL && bus_rdy && req_wr_reg) |=> (cache_wr && st_reg == ST_UPD))
      else $error("write miss data not written after last fill entry");
   a_inval_waits: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg == ST_INVAL && !bus_rdy) |=> (!cache_wr && bus_cmd == CMD_COH_INV))
      else $error("shared write hit wrote before bus ready");
   a_read_hit_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg == ST_LOOK && !stall && !req_wr_reg && !req_flush_reg && p_hit && req_tlb_reg && req_perm_reg)
      |-> (!p_we ##1 (proc_done && proc_ok && !bus_req)))
      else $error("read hit caused bus or state activity");
   a_wt_miss_nowr: assert property (@(posedge pclk) disable iff (!presetn)
      (st_reg == ST_LOOK && !stall && req_wr_reg && !copy_back && !p_hit && !req_flush_reg)
      |-> (!p_we ##1 (!cache_wr && bus_cmd == CMD_COH_WR_INV)))
      else $error("write-through miss touched the cache");
endmodule

// >>> hdl/cache_tag_pkg.sv
// Constants, field layout and encodings for the cache tag and coherency control
// Assumes one clock (pclk) and the system bus sampled on that clock
package cache_tag_pkg;
   localparam int ENTRIES = 4096;
   localparam int INDEX_W = 12;
   localparam int TAG_W = 24;
   localparam int TAG_MSB = 31;
   localparam int TAG_LSB = 8;
   localparam int SU_BIT = 7;
   localparam int SH_BASE = 6;
   localparam int M_BASE = 4;
   localparam int V_BASE = 2;
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] STATUS_OFF = 12'h004;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam int CTRL_COPY_BACK = 0;
   localparam int CTRL_SIZE256 = 1;
   localparam logic [INDEX_W-1:0] SWEEP_LAST = 12'hFFF;
   localparam logic [7:0] ASI_FLUSH_LO = 8'h10;
   localparam logic [7:0] ASI_FLUSH_HI = 8'h14;
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_BLOCK_RD = 3'h1,
      CMD_COH_RD = 3'h2,
      CMD_COH_RD_INV = 3'h3,
      CMD_COH_INV = 3'h4,
      CMD_COH_WR_INV = 3'h5
   } bus_cmd_t;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_LOOK = 6'h02,
      ST_FILL = 6'h04,
      ST_INVAL = 6'h08,
      ST_UPD = 6'h10,
      ST_BUSW = 6'h20
   } proc_state_t;
endpackage

// >>> verif/bus_agent_model.sv
// Far side of the system bus: memory and the other caches answering fills
// Assumes bus_req comes from the block, synchronous to pclk
`timescale 1ns/1ns
module bus_agent_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic bus_req,
   input wire logic [3:0] delay,
   input wire logic other_holds,
   output logic bus_rdy,
   output logic bus_shared_n
);
   logic [3:0] wait_reg;
   // Shared line has a pull-up; a holder pulls it low only with ready
   assign bus_shared_n = ~(bus_rdy & other_holds);
   // One-cycle ready after a chosen stall, so slow answers are covered too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_reg <= '0;
         bus_rdy <= '0;
      end else if (bus_rdy || !bus_req) begin
         wait_reg <= '0;
         bus_rdy <= '0;
      end else if (wait_reg == delay) begin
         bus_rdy <= 1'h1;
      end else begin
         wait_reg <= wait_reg + 4'h1;
      end
   end
endmodule

// >>> verif/cache_tag_coherency_ctl_tb.sv
// Self-checking bench for the cache tag and coherency control block
// Assumes bus_agent_model stands for memory and the other caches
`timescale 1ns/1ns
module cache_tag_coherency_ctl_tb;
   import cache_tag_pkg::*;
   logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, proc_ready, proc_done, proc_hit, proc_ok, cache_wr, bus_req, bus_rdy, bus_shared_n;
   logic power_on_reset_input = '0, proc_req = '0, proc_write = '0, proc_asi_store = '0, proc_super = '0;
   logic tlb_hit = '1, perm_ok = '1, snoop_valid = '0, other_holds = '0, snoop_shared_n, err, tlb_v = '1;
   logic perm_v = '1;
   logic [17:0] internal_module_address = '0;
   logic [23:0] proc_ptag = '0;
   logic [7:0] proc_asi = '0, asi_v = '0;
   logic [3:0] bus_delay = '0;
   logic [63:0] snoop_mad = '0;
   bus_cmd_t bus_cmd, snoop_cmd = CMD_NONE;
   int miscompares = 0, samples_checked = 0;

   cache_tag_coherency_ctl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .power_on_reset_input, .proc_req, .internal_module_address, .proc_ptag, .proc_write,
      .proc_asi_store, .proc_asi, .proc_super, .tlb_hit, .perm_ok, .proc_ready, .proc_done, .proc_hit,
      .proc_ok, .cache_wr, .bus_req, .bus_cmd, .bus_rdy, .bus_shared_n, .snoop_valid, .snoop_cmd, .snoop_mad,
      .snoop_shared_n);
   bus_agent_model far_side (.pclk, .presetn, .bus_req, .delay(bus_delay), .other_holds, .bus_rdy,
      .bus_shared_n);
   always #4 pclk = ~pclk;
   //////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic tmo;
      miscompares++;
      report_and_stop();
   endtask
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   // Zero wait states are expected, but the wait stays open up to a bound
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (n == 50) tmo();
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic mode(input logic cb, input logic s256);
      apb(1, CTRL_OFF, {30'h0, s256, cb});
      apb(0, CTRL_OFF, 32'h0);
      check("ctrl", {s256, cb}, rd);
   endtask
   task automatic far(input logic [3:0] d, input logic h);
      @(posedge pclk);
      bus_delay <= d;
      other_holds <= h;
   endtask
   // One processor access; latency counted from the taking edge, 0 skips it
   task automatic op(input logic w, input logic [17:0] a, input logic [23:0] t,
         input bus_cmd_t ecmd, input logic ewr, input logic eok, input int elat);
      int n;
      bus_cmd_t cmd;
      logic wr;
      n = 0;
      cmd = CMD_NONE;
      wr = '0;
      @(posedge pclk);
      proc_req <= 1'h1;
      proc_write <= w;
      internal_module_address <= a;
      proc_ptag <= t;
      proc_asi <= asi_v;
      proc_asi_store <= (asi_v != 8'h0);
      tlb_hit <= tlb_v;
      perm_ok <= perm_v;
      do begin
         @(posedge pclk);
         n++;
      end while (proc_ready !== 1'h1 && n < 9000);
      if (n == 9000) tmo();
      proc_req <= 1'h0;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
         if (bus_req === 1'h1)
            cmd = bus_cmd;
         if (cache_wr === 1'h1)
            wr = 1'h1;
      end while (proc_done !== 1'h1 && n < 200);
      if (n == 200) tmo();
      asi_v = '0;
      tlb_v = '1;
      perm_v = '1;
      check("bus_cmd", ecmd, cmd);
      check("cache_wr", ewr, wr);
      check("proc_ok", eok, proc_ok);
      // Of the accesses driven here, only a write-through write miss leaves the lookup without a hit
      check("proc_hit", !(ecmd == CMD_COH_WR_INV && !ewr), proc_hit);
      if (elat > 0)
         check("latency", elat, n);
   endtask
   // Snooped transaction in cycle A; shared answer looked for in A+1..A+4
   task automatic snoop(input bus_cmd_t c, input logic [17:0] a, input logic [23:0] t, input logic sh);
      logic [63:0] m;
      m = '0;
      m[35:12] = t;
      m[11:5] = a[11:5];
      m[51:46] = a[17:12];
      @(posedge pclk);
      snoop_valid <= 1'h1;
      snoop_cmd <= c;
      snoop_mad <= m;
      @(posedge pclk);
      snoop_valid <= 1'h0;
      snoop_mad <= ~m;
      for (int i = 1; i < 5; i++) begin
         @(negedge pclk);
         check("snoop_shared_n", !(sh && i == 3), snoop_shared_n);
      end
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      apb(0, STATUS_OFF, 32'h0);
      check("sweeping", 1, rd[0]);
      apb(0, CTRL_OFF, 32'h0);
      check("ctrl reset", {30'h0, CTRL_RESET}, rd);
      apb(1, 12'h008, 32'hFFFFFFFF);
      check("unmapped error", 1, err);
      apb(0, 12'h008, 32'h0);
      check("unmapped data", 0, rd);
   endtask
   task automatic t_copy_back;
      mode(1, 0);
      far(0, 0);
      op(0, 18'h40, 24'hA1, CMD_COH_RD, 0, 1, 0);
      op(0, 18'h40, 24'hA1, CMD_NONE, 0, 1, 2);
      tlb_v = '0;
      op(0, 18'h40, 24'hA1, CMD_NONE, 0, 0, 2);
      perm_v = '0;
      op(0, 18'h40, 24'hA1, CMD_NONE, 0, 0, 2);
      snoop(CMD_COH_RD, 18'h40, 24'hA1, 1);
      snoop(CMD_COH_RD, 18'h40, 24'hA1, 1);
      snoop(CMD_COH_RD, 18'h40, 24'hB1, 0);
      op(1, 18'h40, 24'hA1, CMD_COH_INV, 1, 1, 0);
      snoop(CMD_COH_RD, 18'h40, 24'hA1, 0);
      far(6, 1);
      op(0, 18'h80, 24'hA2, CMD_COH_RD, 0, 1, 0);
      op(1, 18'h80, 24'hA2, CMD_COH_INV, 1, 1, 0);
      far(2, 0);
      op(0, 18'hC0, 24'hA3, CMD_COH_RD, 0, 1, 0);
      op(1, 18'hC0, 24'hA3, CMD_NONE, 1, 1, 2);
      op(1, 18'hE0, 24'hA4, CMD_COH_RD_INV, 1, 1, 0);
      snoop(CMD_COH_RD, 18'hE0, 24'hA4, 0);
      op(0, 18'hE0, 24'h8000A4, CMD_COH_RD, 0, 1, 0);
   endtask
   // Each pass refills the line, so every pass after the first proves the kill
   task automatic t_invalidate;
      bus_cmd_t inv [3] = '{CMD_COH_RD_INV, CMD_COH_INV, CMD_COH_WR_INV};
      for (int i = 0; i < 6; i++) begin
         op(0, 18'h1E0, 24'hA5, CMD_COH_RD, 0, 1, 0);
         if (i < 3) begin
            snoop(inv[i], 18'h1E0, 24'hA5, 0);
         end else if (i < 5) begin
            asi_v = (i == 3) ? ASI_FLUSH_LO : ASI_FLUSH_HI;
            op(1, 18'h1E0, 24'hA5, CMD_NONE, 0, 1, 2);
         end
      end
   endtask
   task automatic t_write_through;
      mode(0, 0);
      op(1, 18'h200, 24'hA6, CMD_COH_WR_INV, 0, 1, 0);
      op(0, 18'h200, 24'hA6, CMD_BLOCK_RD, 0, 1, 0);
      op(0, 18'h200, 24'hA6, CMD_NONE, 0, 1, 2);
      op(1, 18'h200, 24'hA6, CMD_COH_WR_INV, 1, 1, 0);
      snoop(CMD_COH_RD, 18'h200, 24'hA6, 0);
      mode(1, 0);
      op(1, 18'h200, 24'hA6, CMD_NONE, 1, 1, 2);
   endtask
   task automatic t_sub_block;
      mode(1, 1);
      far(1, 0);
      op(0, 18'h100, 24'hA7, CMD_COH_RD, 0, 1, 0);
      op(0, 18'h120, 24'hA7, CMD_COH_RD, 0, 1, 0);
      snoop(CMD_COH_RD, 18'h120, 24'hA7, 1);
      op(0, 18'h100, 24'hA7, CMD_NONE, 0, 1, 2);
   endtask
   task automatic t_power_on;
      @(posedge pclk);
      power_on_reset_input <= 1'h1;
      repeat (3) @(posedge pclk);
      power_on_reset_input <= 1'h0;
      apb(0, STATUS_OFF, 32'h0);
      check("sweeping", 1, rd[0]);
      op(0, 18'h100, 24'hA7, CMD_COH_RD, 0, 1, 0);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      t_regs();
      t_copy_back();
      t_invalidate();
      t_write_through();
      t_sub_block();
      t_power_on();
      report_and_stop();
   end
endmodule
